// ===== frcap_pkg.sv
/*
  frcap_pkg: shared constants for the frame-rate capability register bank:
  register offsets, capability values per product variant, bus responses
  and the register-select enumeration.
  assumes: byte addresses on a 32-bit AXI4-Lite bus, one word per register.
*/
`default_nettype none
package frcap_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_VGA_YUV422  = 12'h20C;  // 640x480 yuv 4:2:2
  localparam logic [11:0] OFF_VGA_MONO8   = 12'h214;  // 640x480 mono 8-bit
  localparam logic [11:0] OFF_VGA_MONO16  = 12'h218;  // 640x480 mono 16-bit
  localparam logic [11:0] OFF_SVGA_YUV422 = 12'h220;  // 800x600 yuv 4:2:2
  localparam logic [11:0] OFF_IGN_CNT     = 12'h300;  // ignored-write counter

  // ----------------------------------------------------------------------
  // rate field layout: bit 0 is 1.875 fps, each bit doubles, bit 7 240 fps
  // ----------------------------------------------------------------------
  localparam int          RATE_BITS      = 8;
  localparam int          RATE_1P875_BIT = 0;
  localparam int          RATE_240_BIT   = 7;
  localparam logic [7:0]  RATE_ALLOWED   = 8'h1F;     // 60/120/240 never shown

  // ----------------------------------------------------------------------
  // capability values, first (v0) and second (v1) variant
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CAPS_VGA_YUV_V0  = 8'h00;
  localparam logic [7:0]  CAPS_VGA_YUV_V1  = 8'h1F;
  localparam logic [7:0]  CAPS_VGA_MONO    = 8'h1F;   // mono8 and mono16
  localparam logic [7:0]  CAPS_SVGA_YUV_V0 = 8'h00;
  localparam logic [7:0]  CAPS_SVGA_YUV_V1 = 8'h0E;   // bit 0 reserved

  // ----------------------------------------------------------------------
  // bus answers and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          IGN_CLR_BIT = 0;            // write 1 here to clear
  localparam logic [15:0] IGN_CNT_RST = 16'h0000;

  // register select, decoded from an address
  typedef enum logic [2:0] {
    SEL_NONE      = 3'b000,
    SEL_VGA_YUV   = 3'b001,
    SEL_VGA_MONO8 = 3'b010,
    SEL_VGA_MONO16= 3'b011,
    SEL_SVGA_YUV  = 3'b100,
    SEL_IGN_CNT   = 3'b101
  } reg_sel_t;

endpackage
`default_nettype wire

// ===== frcap_wr_port.sv
/*
  frcap_wr_port: AXI4-Lite write channels. takes address and data in
  either order, fires one pulse when both are held, then answers on b.
  assumes: the parent decodes wr_addr_out and returns wr_resp_in the
  same cycle as the fire pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module frcap_wr_port
  import frcap_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [DATA_W/8-1:0] wstrb_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  output logic [1:0]             bresp_out,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  output logic [ADDR_W-1:0]      wr_addr_out,
  output logic [DATA_W-1:0]      wr_data_out,
  output logic [DATA_W/8-1:0]    wr_strb_out,
  output logic                   wr_fire_out,
  input  wire logic [1:0]        wr_resp_in
);
  logic aw_held_q;  // address captured, waiting for the pair
  logic w_held_q;   // data captured, waiting for the pair

  // ready drops while a half is held or a response is pending
  assign awready_out = !aw_held_q && !bvalid_out;
  assign wready_out  = !w_held_q && !bvalid_out;
  assign wr_fire_out = aw_held_q && w_held_q && !bvalid_out;

  // address half
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_q   <= 1'b0;
      wr_addr_out <= '0;
    end else if (awvalid_in && awready_out) begin
      aw_held_q   <= 1'b1;
      wr_addr_out <= awaddr_in;
    end else if (wr_fire_out) begin
      aw_held_q   <= 1'b0;
    end
  end

  // data half
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      w_held_q    <= 1'b0;
      wr_data_out <= '0;
      wr_strb_out <= '0;
    end else if (wvalid_in && wready_out) begin
      w_held_q    <= 1'b1;
      wr_data_out <= wdata_in;
      wr_strb_out <= wstrb_in;
    end else if (wr_fire_out) begin
      w_held_q    <= 1'b0;
    end
  end

  // response, held until the master takes it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bvalid_out <= 1'b0;
      bresp_out  <= RESP_OKAY;
    end else if (wr_fire_out) begin
      bvalid_out <= 1'b1;
      bresp_out  <= wr_resp_in;
    end else if (bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== frcap_rd_port.sv
/*
  frcap_rd_port: AXI4-Lite read channels. holds the address one cycle,
  then registers the word and response from the parent's decode.
  assumes: rd_data_in and rd_resp_in follow rd_addr_out combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module frcap_rd_port
  import frcap_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 32
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] araddr_in,
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  output logic [DATA_W-1:0]      rdata_out,
  output logic [1:0]             rresp_out,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  output logic [ADDR_W-1:0]      rd_addr_out,
  input  wire logic [DATA_W-1:0] rd_data_in,
  input  wire logic [1:0]        rd_resp_in
);
  logic ar_held_q;  // address captured, word not yet loaded

  // one read at a time: no new address until the answer is taken
  assign arready_out = !ar_held_q && !rvalid_out;

  // address capture; address stays put while the answer stands
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ar_held_q   <= 1'b0;
      rd_addr_out <= '0;
    end else if (arvalid_in && arready_out) begin
      ar_held_q   <= 1'b1;
      rd_addr_out <= araddr_in;
    end else if (ar_held_q) begin
      ar_held_q   <= 1'b0;
    end
  end

  // answer, held until the master takes it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= '0;
      rresp_out  <= RESP_OKAY;
    end else if (ar_held_q) begin
      rvalid_out <= 1'b1;
      rdata_out  <= rd_data_in;
      rresp_out  <= rd_resp_in;
    end else if (rready_in) begin
      rvalid_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== frame_rate_capability_regs.sv
/*
  frame_rate_capability_regs: read-only frame-rate capability words of a
  camera, one per format/mode, served over AXI4-Lite, plus a counter of
  writes that were ignored.
  assumes: one clock, asynchronous active-high reset, a well-behaved
  AXI4-Lite master with at most one read and one write under way.

  // How it works
  // - bits 0..7: 1.875 fps doubling to 240 fps
  // - vga yuv422 word: zero, or 0x1F on v1
  // - vga mono8 word reads 0x1F always
  // - vga mono16 word reads 0x1F always
  // - svga yuv422: zero, or 0x0E on v1
  // - 60, 120, 240 fps bits never set
  // - one means available, zero means not
*/
`timescale 1ns/1ps
`default_nettype none
module frame_rate_capability_regs
  import frcap_pkg::*;
#(
  parameter int ADDR_W      = 12,
  parameter int DATA_W      = 32,
  parameter int CNT_W       = 16,
  parameter bit VARIANT_SEL = 1'b0   // 0 first variant, 1 second
) (
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [DATA_W-1:0] S_AXI_WDATA_IN,
  input  wire logic [DATA_W/8-1:0] S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [DATA_W-1:0]      S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN
);

  // ----------------------------------------------------------------------
  // variant tables
  // ----------------------------------------------------------------------
  // values are fixed by the variant parameter, nothing can rewrite them
  localparam logic [7:0] TBL_VGA_YUV  = VARIANT_SEL ? CAPS_VGA_YUV_V1 : CAPS_VGA_YUV_V0;
  localparam logic [7:0] TBL_SVGA_YUV = VARIANT_SEL ? CAPS_SVGA_YUV_V1 : CAPS_SVGA_YUV_V0;

  logic [RATE_BITS-1:0] caps_vga_yuv;    // per-rate bits, vga yuv422
  logic [RATE_BITS-1:0] caps_vga_mono8;  // per-rate bits, vga mono8
  logic [RATE_BITS-1:0] caps_vga_mono16; // per-rate bits, vga mono16
  logic [RATE_BITS-1:0] caps_svga_yuv;   // per-rate bits, svga yuv422

  logic [ADDR_W-1:0]    wr_addr;         // held write address
  logic [DATA_W-1:0]    wr_data;         // held write data
  logic [DATA_W/8-1:0]  wr_strb;         // held write strobes
  logic                 wr_fire;         // write pair complete
  logic [1:0]           wr_resp;         // answer for the held write
  logic [ADDR_W-1:0]    rd_addr;         // held read address
  logic [DATA_W-1:0]    rd_word;         // word for the held read
  logic [1:0]           rd_resp;         // answer for the held read
  reg_sel_t             rd_sel;          // decoded read target
  reg_sel_t             wr_sel;          // decoded write target
  logic [CNT_W-1:0]     ign_cnt_q;       // writes dropped so far
  logic                 ign_clr;         // software asks for a clear

  // ----------------------------------------------------------------------
  // capability bits, one slice per rate
  // ----------------------------------------------------------------------
  // the allowed mask is applied per bit so that a table slip can never
  // advertise a rate the sensor cannot hold
  for (genvar b = 0; b < RATE_BITS; b++) begin : g_rate
    // rate b stands for 1.875 fps times two to the power b
    assign caps_vga_yuv[b]    = TBL_VGA_YUV[b] & RATE_ALLOWED[b];
    assign caps_vga_mono8[b]  = CAPS_VGA_MONO[b] & RATE_ALLOWED[b];
    assign caps_vga_mono16[b] = CAPS_VGA_MONO[b] & RATE_ALLOWED[b];
    // bit 0 of the svga word is reserved and forced low
    assign caps_svga_yuv[b]   = (b != RATE_1P875_BIT) &&
                                TBL_SVGA_YUV[b] && RATE_ALLOWED[b];
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // low two address bits are ignored: each register is one aligned word
  always_comb begin
    if (rd_addr[ADDR_W-1:2] == OFF_VGA_YUV422[ADDR_W-1:2]) begin
      rd_sel = SEL_VGA_YUV;
    end else if (rd_addr[ADDR_W-1:2] == OFF_VGA_MONO8[ADDR_W-1:2]) begin
      rd_sel = SEL_VGA_MONO8;
    end else if (rd_addr[ADDR_W-1:2] == OFF_VGA_MONO16[ADDR_W-1:2]) begin
      rd_sel = SEL_VGA_MONO16;
    end else if (rd_addr[ADDR_W-1:2] == OFF_SVGA_YUV422[ADDR_W-1:2]) begin
      rd_sel = SEL_SVGA_YUV;
    end else if (rd_addr[ADDR_W-1:2] == OFF_IGN_CNT[ADDR_W-1:2]) begin
      rd_sel = SEL_IGN_CNT;
    end else begin
      rd_sel = SEL_NONE;  // unmapped
    end
  end

  // same decode for the write side
  always_comb begin
    if (wr_addr[ADDR_W-1:2] == OFF_VGA_YUV422[ADDR_W-1:2]) begin
      wr_sel = SEL_VGA_YUV;
    end else if (wr_addr[ADDR_W-1:2] == OFF_VGA_MONO8[ADDR_W-1:2]) begin
      wr_sel = SEL_VGA_MONO8;
    end else if (wr_addr[ADDR_W-1:2] == OFF_VGA_MONO16[ADDR_W-1:2]) begin
      wr_sel = SEL_VGA_MONO16;
    end else if (wr_addr[ADDR_W-1:2] == OFF_SVGA_YUV422[ADDR_W-1:2]) begin
      wr_sel = SEL_SVGA_YUV;
    end else if (wr_addr[ADDR_W-1:2] == OFF_IGN_CNT[ADDR_W-1:2]) begin
      wr_sel = SEL_IGN_CNT;
    end else begin
      wr_sel = SEL_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // read word mux
  // ----------------------------------------------------------------------
  // upper bits are zero-filled; outside the counter word a one is only ever a real capability
  always_comb begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    case (rd_sel)
      SEL_VGA_YUV:    rd_word[RATE_BITS-1:0] = caps_vga_yuv;
      SEL_VGA_MONO8:  rd_word[RATE_BITS-1:0] = caps_vga_mono8;
      SEL_VGA_MONO16: rd_word[RATE_BITS-1:0] = caps_vga_mono16;
      SEL_SVGA_YUV:   rd_word[RATE_BITS-1:0] = caps_svga_yuv;
      SEL_IGN_CNT:    rd_word[CNT_W-1:0]     = ign_cnt_q;
      default:        rd_resp = RESP_SLVERR;                     // unmapped
    endcase
  end

  // ----------------------------------------------------------------------
  // write handling
  // ----------------------------------------------------------------------
  // inquiry words accept a write with OKAY and drop it; unmapped is an error
  assign wr_resp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
  assign ign_clr = wr_fire && (wr_sel == SEL_IGN_CNT) &&
                   wr_strb[0] && wr_data[IGN_CLR_BIT];

  // counts dropped writes so software can spot a driver writing the
  // inquiry words; saturates rather than wraps to stay meaningful
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ign_cnt_q <= CNT_W'(IGN_CNT_RST);
    end else if (ign_clr) begin
      ign_cnt_q <= '0;
    end else if (wr_fire && (wr_sel != SEL_IGN_CNT) && !(&ign_cnt_q)) begin
      ign_cnt_q <= ign_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // bus channels
  // ----------------------------------------------------------------------
  frcap_wr_port #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_wr (
    .clk_in      (REF_CLK_IN),
    .rst_in      (RST_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data),
    .wr_strb_out (wr_strb),
    .wr_fire_out (wr_fire),
    .wr_resp_in  (wr_resp)
  );

  frcap_rd_port #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_rd (
    .clk_in      (REF_CLK_IN),
    .rst_in      (RST_IN),
    .araddr_in   (S_AXI_ARADDR_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .rd_addr_out (rd_addr),
    .rd_data_in  (rd_word),
    .rd_resp_in  (rd_resp)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // rd_addr stays fixed while rvalid stands, so it names the word shown
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  logic rd_inq;  // the answer on r is for an inquiry word
  assign rd_inq = (rd_sel == SEL_VGA_YUV) || (rd_sel == SEL_VGA_MONO8) ||
                  (rd_sel == SEL_VGA_MONO16) || (rd_sel == SEL_SVGA_YUV);
  logic wr_inq;  // the held write targets an inquiry word
  assign wr_inq = (wr_sel == SEL_VGA_YUV) || (wr_sel == SEL_VGA_MONO8) ||
                  (wr_sel == SEL_VGA_MONO16) || (wr_sel == SEL_SVGA_YUV);

  chk_rate_order: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_VGA_MONO8) |->
      S_AXI_RDATA_OUT[RATE_1P875_BIT] && !S_AXI_RDATA_OUT[RATE_240_BIT]
  ) else $error("mono8 word has wrong slowest or fastest rate bit");

  chk_vga_yuv_word: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_VGA_YUV) |->
      S_AXI_RDATA_OUT == (VARIANT_SEL ? 32'h0000_001F : 32'h0000_0000)
  ) else $error("vga yuv422 capability word wrong");

  chk_mono8_word: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_VGA_MONO8) |->
      S_AXI_RDATA_OUT == 32'h0000_001F
  ) else $error("vga mono8 capability word wrong");

  chk_mono16_word: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_VGA_MONO16) |->
      S_AXI_RDATA_OUT == 32'h0000_001F
  ) else $error("vga mono16 capability word wrong");

  chk_svga_yuv_word: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_SVGA_YUV) |->
      S_AXI_RDATA_OUT == (VARIANT_SEL ? 32'h0000_000E : 32'h0000_0000)
  ) else $error("svga yuv422 capability word wrong");

  chk_fast_rates_off: assert property (
    S_AXI_RVALID_OUT && rd_inq |-> S_AXI_RDATA_OUT[7:5] == 3'h0
  ) else $error("60, 120 or 240 fps advertised");

  chk_avail_meaning: assert property (
    S_AXI_RVALID_OUT && rd_inq |->
      (S_AXI_RRESP_OUT == RESP_OKAY) &&
      ((rd_sel != SEL_VGA_YUV) || ((S_AXI_RDATA_OUT != '0) == VARIANT_SEL))
  ) else $error("availability bits do not match the variant");

  chk_upper_zero: assert property (
    S_AXI_RVALID_OUT && rd_inq |-> S_AXI_RDATA_OUT[DATA_W-1:RATE_BITS] == '0
  ) else $error("reserved bits of an inquiry word not zero");

  chk_write_dropped: assert property (
    wr_fire && wr_inq |=> S_AXI_BVALID_OUT && (S_AXI_BRESP_OUT == RESP_OKAY) ##1
      $stable({caps_vga_yuv, caps_vga_mono8, caps_vga_mono16, caps_svga_yuv})
  ) else $error("write to an inquiry word had an effect");

  // a counter write without the clear bit must leave the count alone
  chk_count_hold: assert property (
    wr_fire && (wr_sel == SEL_IGN_CNT) && !ign_clr |=> $stable(ign_cnt_q)
  ) else $error("counter moved on a write without clear");

  chk_ign_count: assert property (
    wr_fire && (wr_sel != SEL_IGN_CNT) |=>
      (ign_cnt_q == $past(ign_cnt_q) + 1'b1) || (&$past(ign_cnt_q))
  ) else $error("ignored write not counted");

  chk_ign_clear: assert property (
    ign_clr |=> (ign_cnt_q == '0) && S_AXI_BVALID_OUT
  ) else $error("counter clear failed");

  chk_read_timing: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> !S_AXI_RVALID_OUT ##1 S_AXI_RVALID_OUT
  ) else $error("read answer not two cycles after address");

  chk_r_hold: assert property (
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT) && $stable(S_AXI_RRESP_OUT)
  ) else $error("read answer dropped before taken");

  chk_b_hold: assert property (
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)
  ) else $error("write answer dropped before taken");

  chk_unmapped_err: assert property (
    S_AXI_RVALID_OUT && (rd_sel == SEL_NONE) |->
      (S_AXI_RRESP_OUT == RESP_SLVERR) && (S_AXI_RDATA_OUT == '0)
  ) else $error("unmapped read not answered with error");

  cov_read_svga: cover property (S_AXI_RVALID_OUT && (rd_sel == SEL_SVGA_YUV));
  cov_write_inq: cover property (wr_fire && (wr_sel == SEL_VGA_MONO16));
  cov_read_bad:  cover property (S_AXI_RVALID_OUT && (rd_sel == SEL_NONE));
  cov_clear:     cover property (ign_clr && (ign_cnt_q != '0));
  cov_cnt_keep:  cover property (wr_fire && (wr_sel == SEL_IGN_CNT) && !ign_clr);

endmodule
`default_nettype wire

// ===== host_axil_model.sv
/*
  host_axil_model: AXI4-Lite master in the place of the host that reads
  the capability words.
  assumes: one clock; every signal changes just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_axil_model (
  input  wire logic        clk_in,
  output logic      [11:0] awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic      [31:0] wdata_out,
  output logic      [3:0]  wstrb_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  output logic      [11:0] araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out
);
  // --------------------------------------------------------------------
  // idle bus at time zero
  // --------------------------------------------------------------------
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
    {bready_out, araddr_out, arvalid_out, rready_out} = '0;
  end
  // --------------------------------------------------------------------
  // one write: aw and w offered together, each dropped once taken
  // --------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk_in);
    {awaddr_out, wdata_out, wstrb_out} <= {a, d, s};
    {awvalid_out, wvalid_out, bready_out} <= 3'h7;
    forever begin
      @(posedge clk_in);
      // released payload shows the inverse, never the stale value
      if (awvalid_out && awready_in === 1'b1) begin
        {awvalid_out, awaddr_out} <= {1'b0, ~a};
      end
      if (wvalid_out && wready_in === 1'b1) begin
        {wvalid_out, wdata_out, wstrb_out} <= {1'b0, ~d, ~s};
      end
      if (bvalid_in === 1'b1) begin
        r = bresp_in;
        bready_out <= 1'b0;
        break;
      end
    end
  endtask
  // --------------------------------------------------------------------
  // one read, rready held from the start until rvalid is seen
  // --------------------------------------------------------------------
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    {araddr_out, arvalid_out, rready_out} <= {a, 2'h3};
    forever begin
      @(posedge clk_in);
      if (arvalid_out && arready_in === 1'b1) begin
        {arvalid_out, araddr_out} <= {1'b0, ~a};
      end
      if (rvalid_in === 1'b1) begin
        {d, r} = {rdata_in, rresp_in};
        rready_out <= 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ===== test_frame_rate_capability_regs.sv
/*
  test_frame_rate_capability_regs: checks both product variants side by
  side through one host model each.
  assumes: host_axil_model and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_frame_rate_capability_regs
  import frcap_pkg::*;
;
  logic        clk = 1'b0;              // 40 MHz reference
  logic        rst = 1'b1;              // held for 5 cycles
  int          num_errors = 0;          // mismatches seen
  int          n_checks = 0;            // comparisons made
  logic [31:0] d;                       // read word
  logic [1:0]  r;                       // bus answer
  logic [11:0] offs [4] = '{OFF_VGA_YUV422, OFF_VGA_MONO8, OFF_VGA_MONO16, OFF_SVGA_YUV422};
  logic [31:0] caps [2][4] = '{'{32'h0, 32'h1F, 32'h1F, 32'h0}, '{32'h1F, 32'h1F, 32'h1F, 32'hE}};
  always #12.5 clk = ~clk;
  // --------------------------------------------------------------------
  // one design and one host per variant
  // --------------------------------------------------------------------
  for (genvar v = 0; v < 2; v++) begin : g_v
    logic [11:0] awa, ara;
    logic [31:0] wd, rdt;
    logic [3:0]  ws;
    logic [1:0]  bs, rs;
    logic        awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    frame_rate_capability_regs #(.VARIANT_SEL(v == 1)) i_dut (.REF_CLK_IN(clk), .RST_IN(rst),
      .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bs),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdt), .S_AXI_RRESP_OUT(rs), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rr));
    host_axil_model i_host (.clk_in(clk), .awaddr_out(awa), .awvalid_out(awv), .awready_in(awr),
      .wdata_out(wd), .wstrb_out(ws), .wvalid_out(wv), .wready_in(wrd), .bresp_in(bs), .bvalid_in(bv),
      .bready_out(br), .araddr_out(ara), .arvalid_out(arv), .arready_in(arr), .rdata_in(rdt),
      .rresp_in(rs), .rvalid_in(rv), .rready_out(rr));
  end
  // --------------------------------------------------------------------
  // compares, bus dispatch and the verdict
  // --------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s answer %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input int v, input logic [11:0] a);
    if (v == 0) g_v[0].i_host.rd(a, d, r);
    else g_v[1].i_host.rd(a, d, r);
  endtask
  task automatic wr(input int v, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] ws);
    if (v == 0) g_v[0].i_host.wr(a, wd, ws, r);
    else g_v[1].i_host.wr(a, wd, ws, r);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // every capability word of both variants, with the fast rates looked at alone
  task automatic t_caps();
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 4; i++) begin
        rd(v, offs[i]);
        cmp_word(d, caps[v][i], "caps word");
        cmp_word(d & 32'hE0, 32'h0, "fast rates");
        cmp_resp(r, RESP_OKAY, "caps read");
      end
    end
    $display("test caps done");
  endtask
  // writes leave the words alone; only the ignored-write count moves
  task automatic t_writes();
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 4; i++) begin
        wr(v, offs[i], 32'hFFFF_FFFF, 4'hF);
        cmp_resp(r, RESP_OKAY, "caps write");
        rd(v, offs[i]);
        cmp_word(d, caps[v][i], "after write");
      end
      wr(v, 12'h210, 32'h1, 4'hF);
      cmp_resp(r, RESP_SLVERR, "hole write");
      rd(v, 12'h210);
      cmp_resp(r, RESP_SLVERR, "hole read");
      cmp_word(d, 32'h0, "hole data");
      wr(v, OFF_IGN_CNT, 32'h1, 4'hE);
      rd(v, OFF_IGN_CNT);
      cmp_word(d, 32'h5, "count kept");
      wr(v, OFF_IGN_CNT, 32'h1, 4'h1);
      rd(v, OFF_IGN_CNT);
      cmp_word(d, 32'h0, "count cleared");
    end
    $display("test writes done");
  endtask
  // --------------------------------------------------------------------
  // main sequence and watchdog; the run needs far fewer than 4000 cycles
  // --------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp_word({g_v[0].awr, g_v[0].wrd, g_v[0].arr, g_v[0].bv, g_v[0].rv}, 32'h1C, "reset v0");
    cmp_word({g_v[1].awr, g_v[1].wrd, g_v[1].arr, g_v[1].bv, g_v[1].rv}, 32'h1C, "reset v1");
    $display("test reset done");
    t_caps();
    t_writes();
    summarize();
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
